// File: rtl/bff_defines.svh
`ifndef BFF_DEFINES_SVH
`define BFF_DEFINES_SVH
// Queue depth choices for the three capacity variants.
`define BFF_DEPTH_SMALL 12'h800
`define BFF_DEPTH_MID   13'h1000
`define BFF_DEPTH_LARGE 14'h2000
// Depth that this build uses, with its pointer and address widths.
`define BFF_DEPTH       `BFF_DEPTH_SMALL
`define BFF_PTR_W       12
`define BFF_ADDR_W      11
`define BFF_DATA_W      36
`define BFF_PTR_ONE     12'h001
`define BFF_PTR_RST     12'h000
`define BFF_DATA_RST    36'h0_0000_0000
// Direction level that selects a write at port A and at port B.
`define BFF_WR_LEVEL_A  1'b1
`define BFF_WR_LEVEL_B  1'b0
// Flag levels.
`define BFF_HIGH        1'b1
`define BFF_LOW         1'b0
`define BFF_SYNC_RST    3'h0
`endif

// File: rtl/bff_pkg.sv
`include "bff_defines.svh"
package bff_pkg;
  // Control and data pins of one port, sampled together.
  typedef struct packed {
    logic                    chip_select_n;
    logic                    direction;
    logic                    mailbox_select;
    logic                    transfer_enable;
    logic [`BFF_DATA_W-1:0]  data;
  } bff_ctl_t;
  // Status flags presented at one port.
  typedef struct packed {
    logic empty_flag;
    logic full_flag;
    logic almost_empty;
    logic almost_full;
    logic mail_flag;
  } bff_flags_t;
endpackage

// File: rtl/bff_top.sv
`timescale 1ns/1ps
`include "bff_defines.svh"
// Summary of operation
// - Port A empty flag rises after queue two write.
// - Fall-through: port A input ready follows read.
// - Standard: port A full flag rises after read.
// - Fall-through: port B input ready follows read.
// - Standard: port B full flag rises after read.
// - Port B almost-empty rises after port A write.
// - Port A almost-full low at depth minus offset.
// - Port B almost-full rises after port A read.
// - Depth is one of three variant values.
// - Output register word counts as removed.
// - Fall-through first word loads output register.
// - Almost-empty low at offset words or fewer.
// - Mail write lowers flag; opposite read raises.
module bff_top (
  input  wire logic                    clk_sys,
  input  wire logic                    reset,
  input  wire logic                    port_a_clock,
  input  wire logic                    port_b_clock,
  input  wire bff_pkg::bff_ctl_t       port_a_ctl,
  input  wire bff_pkg::bff_ctl_t       port_b_ctl,
  input  wire logic                    fall_through_select,
  input  wire logic [`BFF_PTR_W-1:0]   queue_one_ae_offset,
  input  wire logic [`BFF_PTR_W-1:0]   queue_one_af_offset,
  input  wire logic [`BFF_PTR_W-1:0]   queue_two_ae_offset,
  input  wire logic [`BFF_PTR_W-1:0]   queue_two_af_offset,
  output bff_pkg::bff_flags_t          port_a_flags,
  output bff_pkg::bff_flags_t          port_b_flags,
  output logic [`BFF_DATA_W-1:0]       port_a_rd_data,
  output logic                         port_a_rd_valid,
  input  wire logic                    port_a_rd_ready,
  output logic [`BFF_DATA_W-1:0]       port_b_rd_data,
  output logic                         port_b_rd_valid,
  input  wire logic                    port_b_rd_ready
);

  // Port clock synchronizer chains, one per port.
  logic [2:0]              ck_q [2];
  // Port pin synchronizer stages; stage three lines up with the edge.
  bff_pkg::bff_ctl_t       c1_q [2];
  bff_pkg::bff_ctl_t       c2_q [2];
  bff_pkg::bff_ctl_t       c3_q [2];
  // Mode pin synchronizer.
  logic [1:0]              ft_q;
  wire                     fall_through_select_w = ft_q[1];
  // Per-port edge enables and decoded accesses.
  logic                    ed_w [2];
  logic                    qwr_w [2];
  logic                    qrd_w [2];
  logic                    mwr_w [2];
  logic                    mrd_w [2];
  // Per-port flag flip-flops.
  logic                    emp_q [2];
  logic                    ful_q [2];
  logic                    ae_q [2];
  logic                    af_q [2];
  logic                    mbf_q [2];
  // Per-port read buffer: push side and two entries.
  logic                    push_w [2];
  logic [`BFF_DATA_W-1:0]  pdat_w [2];
  logic                    room_w [2];
  logic                    rdy_w [2];
  logic [`BFF_DATA_W-1:0]  bd0_q [2];
  logic [`BFF_DATA_W-1:0]  bd1_q [2];
  logic [1:0]              bv_q [2];
  // Offsets per queue, indexed by queue.
  logic [`BFF_PTR_W-1:0]   aeo_w [2];
  logic [`BFF_PTR_W-1:0]   afo_w [2];

  assign rdy_w[0] = port_a_rd_ready;
  assign rdy_w[1] = port_b_rd_ready;
  assign aeo_w[0] = queue_one_ae_offset;
  assign aeo_w[1] = queue_two_ae_offset;
  assign afo_w[0] = queue_one_af_offset;
  assign afo_w[1] = queue_two_af_offset;

  // Mode pin passes two flip-flops before use.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ft_q <= 2'h0;
    end
    else
    begin
      ft_q <= {ft_q[0], fall_through_select};
    end
  end

  // Each pass of this loop builds port g and queue g, which port g writes
  // and the opposite port reads, together with mail register g.
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_q
      // Reader port index and write direction level of port g.
      localparam int R = 1 - g;
      localparam logic WLVL = (g == 0) ? `BFF_WR_LEVEL_A : `BFF_WR_LEVEL_B;
      // Queue storage.
      logic [`BFF_DATA_W-1:0] mem [`BFF_DEPTH];
      // Writer side pointer and synchronized reader pointer.
      logic [`BFF_PTR_W-1:0]  wp_q;
      logic [`BFF_PTR_W-1:0]  rs1_q;
      logic [`BFF_PTR_W-1:0]  rs2_q;
      // Reader side pointer, synchronized writer pointer, output register.
      logic [`BFF_PTR_W-1:0]  rp_q;
      logic [`BFF_PTR_W-1:0]  ws1_q;
      logic [`BFF_PTR_W-1:0]  ws2_q;
      logic                   ov_q;
      logic [`BFF_DATA_W-1:0] od_q;
      // Mail register g.
      logic [`BFF_DATA_W-1:0] mail_q;
      // Next values and fill levels.
      logic [`BFF_PTR_W-1:0]  wp_d;
      logic [`BFF_PTR_W-1:0]  rs2_d;
      logic [`BFF_PTR_W-1:0]  rp_d;
      logic [`BFF_PTR_W-1:0]  ws2_d;
      logic [`BFF_PTR_W-1:0]  wcnt_w;
      logic [`BFF_PTR_W-1:0]  rcnt_w;
      logic [`BFF_PTR_W-1:0]  wcnt_d;
      logic [`BFF_PTR_W-1:0]  rcnt_d;
      logic                   wok_w;
      logic                   rok_w;
      logic                   load_w;
      logic                   mrd_ok_w;
      logic                   pop_w;

      // A port edge is a rise of its synchronized clock.
      assign ed_w[g] = ck_q[g][1] & ~ck_q[g][2];
      // Access decode from the pins in place at the edge.
      assign qwr_w[g] = ed_w[g] & ~c3_q[g].chip_select_n & c3_q[g].transfer_enable
                        & ~c3_q[g].mailbox_select & (c3_q[g].direction == WLVL);
      assign qrd_w[g] = ed_w[g] & ~c3_q[g].chip_select_n & c3_q[g].transfer_enable
                        & ~c3_q[g].mailbox_select & (c3_q[g].direction != WLVL);
      assign mwr_w[g] = ed_w[g] & ~c3_q[g].chip_select_n & c3_q[g].transfer_enable
                        & c3_q[g].mailbox_select & (c3_q[g].direction == WLVL);
      assign mrd_w[g] = ed_w[g] & ~c3_q[g].chip_select_n & c3_q[g].transfer_enable
                        & c3_q[g].mailbox_select & (c3_q[g].direction != WLVL);

      // Fill levels as each side sees them.
      assign wcnt_w = wp_q - rs2_q;
      assign rcnt_w = ws2_q - rp_q;
      // A write is taken only while the writer does not see a full queue.
      assign wok_w = qwr_w[g] & (wcnt_w != `BFF_DEPTH);
      // A read needs buffer room and a word: the output register in
      // fall-through mode, the memory in standard mode.
      assign rok_w = qrd_w[R] & room_w[R] & (fall_through_select_w ? ov_q : (rcnt_w != `BFF_PTR_RST));
      // Fall-through refills an empty or draining output register.
      assign load_w = fall_through_select_w & ed_w[R] & (rcnt_w != `BFF_PTR_RST) & (~ov_q | rok_w);
      assign mrd_ok_w = mrd_w[R] & room_w[R];
      // Loading the output register advances the read pointer, so that
      // word no longer counts in the fill level.
      assign rp_d = rp_q + ((load_w | (rok_w & ~fall_through_select_w)) ? `BFF_PTR_ONE : `BFF_PTR_RST);
      assign wp_d = wp_q + (wok_w ? `BFF_PTR_ONE : `BFF_PTR_RST);
      assign rs2_d = ed_w[g] ? rs1_q : rs2_q;
      assign ws2_d = ed_w[R] ? ws1_q : ws2_q;
      assign wcnt_d = wp_d - rs2_d;
      assign rcnt_d = ws2_d - rp_d;
      // Words pushed into the reader's buffer: mail or queue data.
      assign push_w[R] = rok_w | mrd_ok_w;
      assign pdat_w[R] = mrd_ok_w ? mail_q
                         : (fall_through_select_w ? od_q : mem[rp_q[`BFF_ADDR_W-1:0]]);

      // Queue memory write.
      always_ff @(posedge clk_sys)
      begin
        if (wok_w)
        begin
          mem[wp_q[`BFF_ADDR_W-1:0]] <= c3_q[g].data;
        end
      end

      // Writer side: pointer, two-stage reader pointer copy, full and
      // almost-full flags, all stepped on the writer port edge.
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          wp_q     <= `BFF_PTR_RST;
          rs1_q    <= `BFF_PTR_RST;
          rs2_q    <= `BFF_PTR_RST;
          ful_q[g] <= `BFF_HIGH;
          af_q[g]  <= `BFF_HIGH;
        end
        else if (ed_w[g])
        begin
          wp_q     <= wp_d;
          rs1_q    <= rp_q;
          rs2_q    <= rs2_d;
          ful_q[g] <= (wcnt_d != `BFF_DEPTH);
          af_q[g]  <= (wcnt_d < (`BFF_DEPTH - afo_w[g]));
        end
      end

      // Reader side: pointer, two-stage writer pointer copy, output
      // register, empty/output-ready and almost-empty flags.
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          rp_q     <= `BFF_PTR_RST;
          ws1_q    <= `BFF_PTR_RST;
          ws2_q    <= `BFF_PTR_RST;
          ov_q     <= `BFF_LOW;
          od_q     <= `BFF_DATA_RST;
          emp_q[R] <= `BFF_LOW;
          ae_q[R]  <= `BFF_LOW;
        end
        else if (ed_w[R])
        begin
          rp_q     <= rp_d;
          ws1_q    <= wp_q;
          ws2_q    <= ws2_d;
          // Output register holds a word until it is read.
          ov_q     <= load_w | (ov_q & ~rok_w);
          if (load_w)
          begin
            od_q <= mem[rp_q[`BFF_ADDR_W-1:0]];
          end
          // Output ready in fall-through mode, not-empty in standard mode.
          emp_q[R] <= fall_through_select_w ? (load_w | (ov_q & ~rok_w))
                             : (rcnt_d != `BFF_PTR_RST);
          ae_q[R]  <= (rcnt_d > aeo_w[g]);
        end
      end

      // Mail register g: a write while the flag is high stores and lowers
      // it; a read at the opposite port raises it, and a write landing in
      // the same cycle wins.
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          mail_q   <= `BFF_DATA_RST;
          mbf_q[g] <= `BFF_HIGH;
        end
        else if (mwr_w[g] & mbf_q[g])
        begin
          mail_q   <= c3_q[g].data;
          mbf_q[g] <= `BFF_LOW;
        end
        else if (mrd_ok_w)
        begin
          mbf_q[g] <= `BFF_HIGH;
        end
      end

      // Port g pins: the clock passes two flip-flops and the controls three before use.
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          ck_q[g] <= `BFF_SYNC_RST;
          c1_q[g] <= '0;
          c2_q[g] <= '0;
          c3_q[g] <= '0;
        end
        else
        begin
          ck_q[g] <= {ck_q[g][1:0], (g == 0) ? port_a_clock : port_b_clock};
          c1_q[g] <= (g == 0) ? port_a_ctl : port_b_ctl;
          c2_q[g] <= c1_q[g];
          c3_q[g] <= c2_q[g];
        end
      end

      // Two-entry read buffer of port g; a stalled drain blocks reads.
      assign pop_w = bv_q[g][0] & rdy_w[g];
      assign room_w[g] = ~bv_q[g][1] | pop_w;
      always_ff @(posedge clk_sys or posedge reset)
      begin
        if (reset)
        begin
          bd0_q[g] <= `BFF_DATA_RST;
          bd1_q[g] <= `BFF_DATA_RST;
          bv_q[g]  <= 2'h0;
        end
        else
        begin
          // Shift on drain, then place a push in the first free entry.
          if (push_w[g] & ((pop_w ? ~bv_q[g][1] : ~bv_q[g][0])))
          begin
            bd0_q[g] <= pdat_w[g];
          end
          else if (pop_w)
          begin
            bd0_q[g] <= bd1_q[g];
          end
          if (push_w[g] & (pop_w ? bv_q[g][1] : bv_q[g][0]))
          begin
            bd1_q[g] <= pdat_w[g];
          end
          bv_q[g][0] <= (pop_w ? bv_q[g][1] : bv_q[g][0]) | push_w[g];
          bv_q[g][1] <= (pop_w ? 1'b0 : bv_q[g][1])
                        | (push_w[g] & (pop_w ? bv_q[g][1] : bv_q[g][0]));
        end
      end
    end
  endgenerate

  // Outputs come straight from the flag and buffer flip-flops.
  assign port_a_flags    = '{emp_q[0], ful_q[0], ae_q[0], af_q[0], mbf_q[0]};
  assign port_b_flags    = '{emp_q[1], ful_q[1], ae_q[1], af_q[1], mbf_q[1]};
  assign port_a_rd_data  = bd0_q[0];
  assign port_a_rd_valid = bv_q[0][0];
  assign port_b_rd_data  = bd0_q[1];
  assign port_b_rd_valid = bv_q[1][0];

endmodule // bff_top

// File: test/bff_port_host.sv
`timescale 1ns/1ps
// Stands in for the processors: free-running port clocks and read sinks.
module bff_port_host #(
  parameter int HALF_A = 5, // System cycles in each port A clock phase.
  parameter int HALF_B = 6  // System cycles in each port B clock phase.
) (
  input  wire logic clk_sys,
  input  wire logic stall_b,
  output logic      port_a_clock,
  output logic      port_b_clock,
  output logic      port_a_rd_ready,
  output logic      port_b_rd_ready
);
  int cnt_a = 0; // Phase counter of port A.
  int cnt_b = 0; // Phase counter of port B.
  initial
  begin
    port_a_clock = 1'b0;
    port_b_clock = 1'b0;
    port_a_rd_ready = 1'b1;
    port_b_rd_ready = 1'b1;
  end
  // Clocks move off the sampling edge; the port B sink stalls on request.
  always @(negedge clk_sys)
  begin
    cnt_a <= (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
    cnt_b <= (cnt_b == HALF_B - 1) ? 0 : cnt_b + 1;
    port_a_clock <= port_a_clock ^ (cnt_a == HALF_A - 1);
    port_b_clock <= port_b_clock ^ (cnt_b == HALF_B - 1);
    port_b_rd_ready <= !stall_b;
  end
endmodule // bff_port_host

// File: test/bff_top_chk.sv
`timescale 1ns/1ps
`include "bff_defines.svh"
// Watches flag timing, reset state and port B read word holding at the pins.
module bff_top_chk (
  input wire logic                   clk_sys,
  input wire logic                   reset,
  input wire logic                   port_a_clock,
  input wire logic                   port_b_clock,
  input wire bff_pkg::bff_flags_t    port_a_flags,
  input wire bff_pkg::bff_flags_t    port_b_flags,
  input wire logic                   port_a_rd_valid,
  input wire logic [`BFF_DATA_W-1:0] port_b_rd_data,
  input wire logic                   port_b_rd_valid,
  input wire logic                   port_b_rd_ready
);
  logic       a_q;     // Last sampled port A clock.
  logic       b_q;     // Last sampled port B clock.
  logic [3:0] age_a_q; // Cycles since port A clock rose, saturating.
  logic [3:0] age_b_q; // Cycles since port B clock rose, saturating.
  wire logic [3:0] age_a_d = (port_a_clock && !a_q) ? 4'h0 : age_a_q + {3'h0, age_a_q != 4'hF};
  wire logic [3:0] age_b_d = (port_b_clock && !b_q) ? 4'h0 : age_b_q + {3'h0, age_b_q != 4'hF};
  // Tracks both port clocks.
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      a_q     <= 1'b0;
      b_q     <= 1'b0;
      age_a_q <= 4'hF;
      age_b_q <= 4'hF;
    end
    else
    begin
      a_q     <= port_a_clock;
      b_q     <= port_b_clock;
      age_a_q <= age_a_d;
      age_b_q <= age_b_d;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  rst_a_a: assert property ($fell(reset) |-> port_a_flags == 5'h0B && !port_a_rd_valid)
    else $error("port A not in reset state");
  rst_b_a: assert property ($fell(reset) |-> port_b_flags == 5'h0B && !port_b_rd_valid)
    else $error("port B not in reset state");
  hold_b_a: assert property (port_b_rd_valid && !port_b_rd_ready
    |=> port_b_rd_valid && $stable(port_b_rd_data)) else $error("port B word moved");
  // The mail flag is raised by the opposite port, so only the four queue flags
  // are tied to this port's own clock.
  edge_a_a: assert property ($changed(port_a_flags[4:1]) |-> age_a_q <= 4'h6)
    else $error("port A flags moved away from a port A edge");
  edge_b_a: assert property ($changed(port_b_flags[4:1]) |-> age_b_q <= 4'h6)
    else $error("port B flags moved away from a port B edge");
  ae_word_a_a: assert property (port_a_flags.almost_empty |-> port_a_flags.empty_flag)
    else $error("port A almost empty high with queue two empty");
  ae_word_b_a: assert property (port_b_flags.almost_empty |-> port_b_flags.empty_flag)
    else $error("port B almost empty high with no word ready");
  full_af_a_a: assert property (!port_a_flags.full_flag |-> !port_a_flags.almost_full)
    else $error("port A full without almost full");
  full_af_b_a: assert property (!port_b_flags.full_flag |-> !port_b_flags.almost_full)
    else $error("port B full without almost full");
  rdv_b_a: assert property ($rose(port_b_rd_valid) |-> age_b_q <= 4'h6)
    else $error("port B word appeared away from a port B edge");
  cover property ($rose(port_a_flags.empty_flag));
  cover property (port_b_rd_valid && port_b_rd_ready);
  cover property ($fell(port_a_flags.full_flag));
endmodule // bff_top_chk
bind bff_top bff_top_chk bff_top_chk_inst (.clk_sys(clk_sys), .reset(reset),
  .port_a_clock(port_a_clock), .port_b_clock(port_b_clock), .port_a_flags(port_a_flags),
  .port_b_flags(port_b_flags), .port_a_rd_valid(port_a_rd_valid),
  .port_b_rd_data(port_b_rd_data), .port_b_rd_valid(port_b_rd_valid),
  .port_b_rd_ready(port_b_rd_ready));

// File: test/testbench.sv
`timescale 1ns/1ps
`include "bff_defines.svh"
// Drives both ports, notes each expected word and checks the flags.
module testbench;
  localparam int AE = 9, AF = 8, AA = 7, AL = 6, AM = 5, BE = 4, BA = 2; // Flag positions.
  logic                   clk_sys, reset, fts, stall_b;      // Clock, reset, mode, sink stall.
  logic                   pa_clk, pb_clk, pa_rdy, pb_rdy;    // Partner outputs.
  logic                   pa_vld, pb_vld;                    // Read word valid.
  bff_pkg::bff_ctl_t      pa_ctl, pb_ctl;                    // Port pins.
  bff_pkg::bff_flags_t    pa_flg, pb_flg;                    // Port flags.
  logic [`BFF_DATA_W-1:0] pa_dat, pb_dat, d;                 // Read words and a scratch word.
  logic [`BFF_DATA_W-1:0] exp_a[$], exp_b[$];                // Words each port reads next.
  int                     mismatches, n_tests, i;
  wire logic [9:0]        flg = {pa_flg, pb_flg};
  bff_top bff_top_inst (.clk_sys(clk_sys), .reset(reset), .port_a_clock(pa_clk),
    .port_b_clock(pb_clk), .port_a_ctl(pa_ctl), .port_b_ctl(pb_ctl), .fall_through_select(fts),
    .queue_one_ae_offset(12'h002), .queue_one_af_offset(12'h003),
    .queue_two_ae_offset(12'h002), .queue_two_af_offset(12'h003), .port_a_flags(pa_flg),
    .port_b_flags(pb_flg), .port_a_rd_data(pa_dat), .port_a_rd_valid(pa_vld),
    .port_a_rd_ready(pa_rdy), .port_b_rd_data(pb_dat), .port_b_rd_valid(pb_vld),
    .port_b_rd_ready(pb_rdy));
  bff_port_host bff_port_host_inst (.clk_sys(clk_sys), .stall_b(stall_b), .port_a_clock(pa_clk),
    .port_b_clock(pb_clk), .port_a_rd_ready(pa_rdy), .port_b_rd_ready(pb_rdy));
  // Counts a comparison and reports a difference.
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] want);
    n_tests++;
    if (seen !== want)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask
  // Prints the verdict and stops.
  task automatic test_done();
    if (mismatches == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Waits, bounded, for a port clock level.
  task automatic wait_clk(input logic is_a, input logic lvl);
    for (int n = 0; (is_a ? pa_clk : pb_clk) !== lvl; n++)
    begin
      if (n == 50)
      begin
        mismatches++;
        test_done();
      end
      @(negedge clk_sys);
    end
  endtask
  // Waits, bounded, for a flag level; a late flag is a mismatch.
  task automatic wait_flag(input int idx, input logic lvl);
    int n;
    for (n = 0; n < 48 && flg[idx] !== lvl; n++)
      @(negedge clk_sys);
    check($sformatf("flag%0d", idx), flg[idx], lvl);
    if (n == 48)
      test_done();
  endtask
  // Holds one request from a low phase through the whole next high phase.
  task automatic access(input logic is_a, input logic wr, input logic mb, input logic [35:0] w);
    logic dir;
    dir = is_a ? (wr ~^ `BFF_WR_LEVEL_A) : (wr ~^ `BFF_WR_LEVEL_B);
    // Finding a fresh fall keeps the pins ahead of the rise by several cycles.
    wait_clk(is_a, 1'b1);
    wait_clk(is_a, 1'b0);
    @(negedge clk_sys);
    if (is_a)
      pa_ctl = '{1'b0, dir, mb, 1'b1, w};
    else
      pb_ctl = '{1'b0, dir, mb, 1'b1, w};
    wait_clk(is_a, 1'b1);
    wait_clk(is_a, 1'b0);
    if (is_a)
      pa_ctl.transfer_enable = 1'b0;
    else
      pb_ctl.transfer_enable = 1'b0;
  endtask
  // Resets in the chosen mode and clears the notes.
  task automatic do_reset(input logic mode);
    @(negedge clk_sys);
    reset = 1'b1;
    fts = mode;
    exp_a.delete();
    exp_b.delete();
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    check("a_flags", pa_flg, 5'h0B);
    check("b_flags", pb_flg, 5'h0B);
  endtask
  function automatic logic [35:0] rnd();
    logic [63:0] r;
    r = {$urandom, $urandom};
    return r[35:0];
  endfunction
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Takes the oldest note whenever a port hands over a word.
  always @(posedge clk_sys)
  begin
    if (!reset && pa_vld === 1'b1 && pa_rdy === 1'b1)
      check("a_word", pa_dat, exp_a.size() ? exp_a.pop_front() : 'x);
    if (!reset && pb_vld === 1'b1 && pb_rdy === 1'b1)
      check("b_word", pb_dat, exp_b.size() ? exp_b.pop_front() : 'x);
  end
  initial
  begin
    {fts, stall_b, mismatches, n_tests} = '0;
    reset = 1'b1;
    pa_ctl = '{1'b1, 1'b0, 1'b0, 1'b0, 36'h0};
    pb_ctl = '{1'b1, 1'b0, 1'b0, 1'b0, 36'h0};
    void'($urandom(26));
    do_reset(1'b0);
    // Mail one: a second write while mail is pending is dropped.
    d = rnd();
    exp_b.push_back(d);
    access(1'b1, 1'b1, 1'b1, d);
    wait_flag(AM, 1'b0);
    access(1'b1, 1'b1, 1'b1, ~d);
    access(1'b0, 1'b0, 1'b1, 36'h0);
    wait_flag(AM, 1'b1);
    // Queue two: three words from port B, read back at port A.
    for (i = 0; i < 3; i++)
    begin
      d = rnd();
      exp_a.push_back(d);
      access(1'b0, 1'b1, 1'b0, d);
      if (i == 0)
        wait_flag(AE, 1'b1);
      if (i == 1)
      begin
        repeat (48) @(negedge clk_sys);
        check("a_ae", pa_flg.almost_empty, 1'b0);
      end
    end
    wait_flag(AA, 1'b1);
    repeat (3) access(1'b1, 1'b0, 1'b0, 36'h0);
    wait_flag(AE, 1'b0);
    // Queue one: fill with port B stalled, overflow, then read past the levels.
    stall_b = 1'b1;
    for (i = 0; i < `BFF_DEPTH; i++)
    begin
      d = rnd();
      exp_b.push_back(d);
      access(1'b1, 1'b1, 1'b0, d);
      if (i == 2)
        wait_flag(BA, 1'b1);
    end
    wait_flag(AF, 1'b0);
    check("a_af", pa_flg.almost_full, 1'b0);
    access(1'b1, 1'b1, 1'b0, rnd());
    repeat (4) access(1'b0, 1'b0, 1'b0, 36'h0);
    check("b_valid", pb_vld, 1'b1);
    stall_b = 1'b0;
    wait_flag(AF, 1'b1);
    check("a_af", pa_flg.almost_full, 1'b0);
    repeat (2) access(1'b0, 1'b0, 1'b0, 36'h0);
    wait_flag(AL, 1'b1);
    repeat (20) @(negedge clk_sys);
    check("b_left", exp_b.size(), `BFF_DEPTH - 4);
    // Fall-through: the first word waits in the output register unread.
    do_reset(1'b1);
    for (i = 0; i < 4; i++)
    begin
      d = rnd();
      exp_b.push_back(d);
      access(1'b1, 1'b1, 1'b0, d);
      if (i == 0)
        wait_flag(BE, 1'b1);
      if (i == 2)
      begin
        repeat (48) @(negedge clk_sys);
        check("b_ae", pb_flg.almost_empty, 1'b0);
        check("b_valid", pb_vld, 1'b0);
      end
    end
    wait_flag(BA, 1'b1);
    for (i = 0; i < 8 && pb_flg.empty_flag === 1'b1; i++)
      access(1'b0, 1'b0, 1'b0, 36'h0);
    repeat (20) @(negedge clk_sys);
    check("left", exp_a.size() + exp_b.size(), 36'h0);
    test_done();
  end
endmodule // testbench
